// file: rtdc_drive_control.sv
/*
 * Transmitter drive control: three configuration registers on an 8-bit
 * register port, modulation source selection and inversion, overshoot
 * extension, and the two transmitter pin drives.
 * Assumes envelope and carrier tick come from logic on the same clock;
 * the external signal input is asynchronous and is synchronised here.
 */
// Summary of operation
// R1: Invert bit inverts second output pin
// R2: Invert bit inverts first output pin
// R3: Enable bit enables both output pins
// R4: Software avoids codes 011b and 110b
// R5: Clock mode field selects output style
// R6: Two-bit amplitude reduction forwarded to driver
// R7: Carrier maximum overrides amplitude reduction
// R8: Five-bit residual carrier level applied
// R9: Overshoot field extends modulation carrier clocks
// R10: Invert bit inverts selected modulation
// R11: Select none, envelope, or external input
// R12: Reserved bits ignore writes, read zero
`timescale 1ns/1ps
module rtdc_drive_control
    import rtdc_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       resetn,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    input  wire logic [7:0] reg_wdata,
    output logic [7:0]      reg_rdata,
    input  wire logic       internal_transmit_envelope,
    input  wire logic       external_signal_input,
    input  wire logic       carrier_tick,
    output rtdc_analog_t    analog_q,
    output rtdc_pins_t      pins_q,
    output logic            modulation_q,
    output logic            mode_invalid_q
);

    logic [7:0] driver_mode_control_q;
    logic [7:0] carrier_amplitude_control_q;
    logic [7:0] modulation_source_control_q;
    logic [7:0] rdata_d;
    logic       ext_sync1_q;
    logic       ext_sync2_q;

    // Address decode
    wire sel_mode = (reg_addr == RTDC_ADDR_DRIVER_MODE);
    wire sel_amp  = (reg_addr == RTDC_ADDR_CARRIER_AMP);
    wire sel_src  = (reg_addr == RTDC_ADDR_MOD_SOURCE);

    // Field extraction
    wire       pin_two_invert = driver_mode_control_q[RTDC_POS_PIN_TWO_INV];
    wire       pin_one_invert = driver_mode_control_q[RTDC_POS_PIN_ONE_INV];
    wire       driver_enable  = driver_mode_control_q[RTDC_POS_DRV_ENABLE];
    wire [2:0] driver_clock_mode = driver_mode_control_q[RTDC_POS_CLK_MODE +: 3];
    wire [1:0] carrier_amplitude_reduction =
        carrier_amplitude_control_q[RTDC_POS_AMP_RED +: 2];
    wire [4:0] residual_level = carrier_amplitude_control_q[RTDC_POS_RESIDUAL +: 5];
    wire [3:0] second_overshoot_length =
        modulation_source_control_q[RTDC_POS_OVERSHOOT +: 4];
    wire       carrier_max       = modulation_source_control_q[RTDC_POS_CARRIER_MAX];
    wire       modulation_invert = modulation_source_control_q[RTDC_POS_MOD_INVERT];
    wire [1:0] modulation_source_select =
        modulation_source_control_q[RTDC_POS_MOD_SEL +: 2];

    // Register writes; reserved bits are masked so they never store
    always_ff @(posedge clock) begin
        if (!resetn) begin
            driver_mode_control_q       <= RTDC_RST_DRIVER_MODE;
            carrier_amplitude_control_q <= RTDC_RST_CARRIER_AMP;
            modulation_source_control_q <= RTDC_RST_MOD_SOURCE;
        end else if (reg_write) begin
            if (sel_mode) driver_mode_control_q <= reg_wdata & RTDC_MASK_DRIVER_MODE; // R12
            if (sel_amp) carrier_amplitude_control_q <= reg_wdata & RTDC_MASK_CARRIER_AMP; // R12
            if (sel_src) modulation_source_control_q <= reg_wdata & RTDC_MASK_MOD_SOURCE;
        end
    end

    // Read mux; unmapped addresses read zero
    assign rdata_d = sel_mode ? driver_mode_control_q :
                     sel_amp  ? carrier_amplitude_control_q :
                     sel_src  ? modulation_source_control_q : 8'h00;

    always_ff @(posedge clock) begin
        if (!resetn) reg_rdata <= 8'h00;
        else if (reg_read) reg_rdata <= rdata_d;
    end

    // External input is asynchronous: two flops before use
    always_ff @(posedge clock) begin
        if (!resetn) begin
            ext_sync1_q <= 1'b0;
            ext_sync2_q <= 1'b0;
        end else begin
            ext_sync1_q <= external_signal_input;
            ext_sync2_q <= ext_sync1_q;
        end
    end

    // Source select; reserved code gives no modulation
    wire mod_raw = (modulation_source_select == RTDC_SEL_ENVELOPE) ? internal_transmit_envelope :
                   (modulation_source_select == RTDC_SEL_EXTERNAL) ? ext_sync2_q :
                   1'b0; // R11
    wire mod_sel = mod_raw ^ modulation_invert; // R10
    wire mod_ext;

    rtdc_overshoot #(
        .LEN_W (4)
    ) u_overshoot (
        .clock        (clock),
        .resetn       (resetn),
        .carrier_tick (carrier_tick),
        .length       (second_overshoot_length),
        .mod_in       (mod_sel),
        .mod_out      (mod_ext)
    );

    // Pin drive: base level is the modulation, each pin inverted on request
    wire pin_one_d = mod_ext ^ pin_one_invert; // R2
    wire pin_two_d = mod_ext ^ pin_two_invert; // R1
    // Unsupported clock codes are flagged; software must avoid them
    wire bad_mode  = (driver_clock_mode == RTDC_CLK_MODE_BAD_A) ||
                     (driver_clock_mode == RTDC_CLK_MODE_BAD_B); // R4

    // Output registers
    always_ff @(posedge clock) begin
        if (!resetn) begin
            pins_q         <= '0;
            analog_q       <= '0;
            modulation_q   <= 1'b0;
            mode_invalid_q <= 1'b0;
        end else begin
            pins_q.first_drive   <= pin_one_d;
            pins_q.second_drive  <= pin_two_d;
            pins_q.first_enable  <= driver_enable; // R3
            pins_q.second_enable <= driver_enable; // R3
            analog_q.clock_mode  <= driver_clock_mode; // R5
            // Carrier max wins; reduction reads as zero to the driver then
            analog_q.amplitude_reduction <= carrier_max ? 2'h0 : carrier_amplitude_reduction; // R6 R7
            analog_q.carrier_max    <= carrier_max; // R7
            analog_q.residual_level <= residual_level; // R8
            modulation_q   <= mod_ext;
            mode_invalid_q <= bad_mode;
        end
    end

    enable_both_a: assert property (@(posedge clock) disable iff (!resetn) // R3
        1'b1 |=> (pins_q.first_enable == $past(driver_enable)) &&
                 (pins_q.second_enable == $past(driver_enable)))
        else $error("pin enables do not follow driver enable");

    pin_one_inv_a: assert property (@(posedge clock) disable iff (!resetn) // R2
        1'b1 |=> pins_q.first_drive == ($past(mod_ext) ^ $past(pin_one_invert)))
        else $error("first pin inversion wrong");

    pin_two_inv_a: assert property (@(posedge clock) disable iff (!resetn) // R1
        1'b1 |=> pins_q.second_drive == ($past(mod_ext) ^ $past(pin_two_invert)))
        else $error("second pin inversion wrong");

    clock_mode_a: assert property (@(posedge clock) disable iff (!resetn) // R5
        1'b1 |=> analog_q.clock_mode == $past(driver_clock_mode))
        else $error("clock mode not forwarded");

    cw_max_a: assert property (@(posedge clock) disable iff (!resetn) // R7
        carrier_max |=> analog_q.carrier_max && analog_q.amplitude_reduction == 2'h0)
        else $error("carrier max did not override reduction");

    amp_fwd_a: assert property (@(posedge clock) disable iff (!resetn) // R6
        !carrier_max |=> analog_q.amplitude_reduction == $past(carrier_amplitude_reduction))
        else $error("amplitude reduction not forwarded");

    residual_a: assert property (@(posedge clock) disable iff (!resetn) // R8
        1'b1 |=> analog_q.residual_level == $past(residual_level))
        else $error("residual level not forwarded");

    no_mod_a: assert property (@(posedge clock) disable iff (!resetn) // R11
        (modulation_source_select == RTDC_SEL_NONE) |-> mod_raw == 1'b0)
        else $error("modulation present with no source");

    mod_inv_a: assert property (@(posedge clock) disable iff (!resetn) // R10
        mod_sel == (mod_raw ^ modulation_invert))
        else $error("modulation inversion wrong");

    reserved_a: assert property (@(posedge clock) disable iff (!resetn) // R12
        (driver_mode_control_q[5:4] == 2'b00) && !carrier_amplitude_control_q[5])
        else $error("reserved bit stored");

    // Register port reads, split by where the address lands
    sequence read_mode_s;
        reg_read && sel_mode;
    endsequence

    sequence read_amp_s;
        reg_read && sel_amp;
    endsequence

    sequence read_unmapped_s;
        reg_read && !sel_mode && !sel_amp && !sel_src;
    endsequence

    mode_rsvd_rd_a: assert property (@(posedge clock) disable iff (!resetn) // R12
        read_mode_s |=> reg_rdata[5:4] == 2'b00)
        else $error("reserved mode bits read back set");

    amp_rsvd_rd_a: assert property (@(posedge clock) disable iff (!resetn) // R12
        read_amp_s |=> !reg_rdata[5])
        else $error("reserved amplitude bit read back set");

    unmapped_rd_a: assert property (@(posedge clock) disable iff (!resetn) // R12
        read_unmapped_s |=> reg_rdata == 8'h00)
        else $error("unmapped address read back nonzero");

    mode_flag_a: assert property (@(posedge clock) disable iff (!resetn) // R4
        1'b1 |=> mode_invalid_q == ($past(driver_clock_mode) inside {3'h3, 3'h6}))
        else $error("unsupported clock mode not flagged");

    // Selected source reaches the inverter unchanged
    src_env_a: assert property (@(posedge clock) disable iff (!resetn) // R11
        (modulation_source_select == RTDC_SEL_ENVELOPE) |->
            mod_sel == (internal_transmit_envelope ^ modulation_invert))
        else $error("envelope not selected as modulation source");

    src_ext_a: assert property (@(posedge clock) disable iff (!resetn) // R11
        (modulation_source_select == RTDC_SEL_EXTERNAL) |->
            mod_sel == (ext_sync2_q ^ modulation_invert))
        else $error("external input not selected as modulation source");

    // With no source an inverted modulation must stand high at the output
    mod_inv_out_a: assert property (@(posedge clock) disable iff (!resetn) // R10
        (modulation_source_select == RTDC_SEL_NONE) && modulation_invert |=> modulation_q)
        else $error("inverted idle modulation not driven");

endmodule : rtdc_drive_control

// file: rtdc_pkg.sv
/*
 * Package for the transmitter drive control block: register offsets,
 * field positions, reset values, encodings and shared driver types.
 * Assumes an 8-bit register port with byte addresses.
 */
package rtdc_pkg;

    // Register offsets
    localparam logic [7:0] RTDC_ADDR_DRIVER_MODE = 8'h28;
    localparam logic [7:0] RTDC_ADDR_CARRIER_AMP = 8'h29;
    localparam logic [7:0] RTDC_ADDR_MOD_SOURCE  = 8'h2A;

    // Reset values
    localparam logic [7:0] RTDC_RST_DRIVER_MODE = 8'h00;
    localparam logic [7:0] RTDC_RST_CARRIER_AMP = 8'h00;
    localparam logic [7:0] RTDC_RST_MOD_SOURCE  = 8'h00;

    // Writable bit masks; reserved bits read as zero
    localparam logic [7:0] RTDC_MASK_DRIVER_MODE = 8'hCF;
    localparam logic [7:0] RTDC_MASK_CARRIER_AMP = 8'hDF;
    localparam logic [7:0] RTDC_MASK_MOD_SOURCE  = 8'hFF;

    // Field positions
    localparam int RTDC_POS_PIN_TWO_INV  = 7;
    localparam int RTDC_POS_PIN_ONE_INV  = 6;
    localparam int RTDC_POS_DRV_ENABLE   = 3;
    localparam int RTDC_POS_CLK_MODE     = 0;
    localparam int RTDC_POS_AMP_RED      = 6;
    localparam int RTDC_POS_RESIDUAL     = 0;
    localparam int RTDC_POS_OVERSHOOT    = 4;
    localparam int RTDC_POS_CARRIER_MAX  = 3;
    localparam int RTDC_POS_MOD_INVERT   = 2;
    localparam int RTDC_POS_MOD_SEL      = 0;

    // Driver clock mode codes that software must not use
    localparam logic [2:0] RTDC_CLK_MODE_BAD_A = 3'h3;
    localparam logic [2:0] RTDC_CLK_MODE_BAD_B = 3'h6;

    // Modulation source encodings
    localparam logic [1:0] RTDC_SEL_NONE     = 2'h0;
    localparam logic [1:0] RTDC_SEL_ENVELOPE = 2'h1;
    localparam logic [1:0] RTDC_SEL_EXTERNAL = 2'h2;

    // Settings handed to the analog drivers
    typedef struct packed {
        logic [2:0] clock_mode;
        logic [1:0] amplitude_reduction;
        logic       carrier_max;
        logic [4:0] residual_level;
    } rtdc_analog_t;

    // Drive values for the two transmitter pins
    typedef struct packed {
        logic first_drive;
        logic first_enable;
        logic second_drive;
        logic second_enable;
    } rtdc_pins_t;

endpackage : rtdc_pkg

// file: rtdc_overshoot.sv
/*
 * Overshoot extension: stretches the end of the modulation pulse by a
 * programmable number of carrier clocks.
 * Assumes carrier_tick is a one-cycle pulse on the system clock.
 */
`timescale 1ns/1ps
module rtdc_overshoot
    import rtdc_pkg::*;
#(
    parameter int LEN_W = 4
) (
    input  wire logic             clock,
    input  wire logic             resetn,
    input  wire logic             carrier_tick,
    input  wire logic [LEN_W-1:0] length,
    input  wire logic             mod_in,
    output logic                  mod_out
);

    // The counter needs at least one bit and stays small enough to compare cheaply
    if (LEN_W < 1 || LEN_W > 8) begin : g_len_check
        $error("rtdc_overshoot: LEN_W out of range");
    end

    logic             mod_prev_q;
    logic [LEN_W-1:0] count_q;
    logic [LEN_W-1:0] count_d;
    logic             falling;

    // A falling edge of modulation loads the extension length
    assign falling = mod_prev_q & ~mod_in;
    assign count_d = falling ? length :
                     ((carrier_tick && count_q != '0) ? count_q - 1'b1 : count_q);

    // Counter and edge history
    always_ff @(posedge clock) begin
        if (!resetn) begin
            mod_prev_q <= 1'b0;
            count_q    <= '0;
        end else begin
            mod_prev_q <= mod_in;
            count_q    <= count_d;
        end
    end

    // Modulation stays active while extension carrier clocks remain; the fall
    // cycle itself is covered too, else the pulse would dip for one clock
    assign mod_out = mod_in | (falling && (length != '0)) | (count_q != '0); // R9

    ext_holds_a: assert property (@(posedge clock) disable iff (!resetn) // R9
        (count_q != '0) |-> mod_out)
        else $error("modulation dropped during overshoot extension");

    // A fall with a nonzero length must keep modulation up and load the count
    sequence mod_fall_s;
        $fell(mod_in) && (length != '0);
    endsequence

    ext_load_a: assert property (@(posedge clock) disable iff (!resetn) // R9
        mod_fall_s |-> mod_out ##1 (count_q == $past(length)))
        else $error("overshoot extension not loaded on fall");

endmodule : rtdc_overshoot

// file: rtdc_drv_model.sv
/*
 * Behavioural model of the analog transmitter drivers at the antenna.
 * Assumes settings and pin drives come straight from the control block.
 */
`timescale 1ns/1ps
module rtdc_drv_model
    import rtdc_pkg::*;
(
    input  wire logic         clock,
    input  wire rtdc_analog_t analog,
    input  wire rtdc_pins_t   pins,
    output logic              first_level,
    output logic              second_level,
    output logic [15:0]       drop_mv
);
    logic toggle_q = 1'b0;

    // A released pin floats: show a changing pattern so stale values never pass
    always @(posedge clock) begin
        toggle_q <= ~toggle_q;
    end
    assign first_level  = pins.first_enable ? pins.first_drive : toggle_q;
    assign second_level = pins.second_enable ? pins.second_drive : ~toggle_q;

    // Headroom below the supply in mV; maximum carrier spends none
    always_comb begin
        case (analog.amplitude_reduction)
            2'h0:    drop_mv = 16'h0064;
            2'h1:    drop_mv = 16'h00FA;
            2'h2:    drop_mv = 16'h01F4;
            default: drop_mv = 16'h03E8;
        endcase
        if (analog.carrier_max) begin
            drop_mv = 16'h0000;
        end
    end
endmodule : rtdc_drv_model

// file: tb.sv
/*
 * Self-checking bench for the transmitter drive control block.
 * Assumes the register port and driver model as declared; inputs at negedge.
 */
`timescale 1ns/1ps
module tb
    import rtdc_pkg::*;
;
    logic         clock, resetn, reg_write, reg_read, env, ext, tick;
    logic [7:0]   reg_addr, reg_wdata, reg_rdata, rd_val;
    rtdc_analog_t analog_q;
    rtdc_pins_t   pins_q;
    logic         modulation_q, mode_invalid_q, first_level, second_level;
    logic [15:0]  drop_mv;
    logic [15:0]  drops [4] = '{16'h0064, 16'h00FA, 16'h01F4, 16'h03E8};
    logic [7:0]   sels [8]  = '{8'h00, 8'h01, 8'h05, 8'h02, 8'h06, 8'h03, 8'h07, 8'h04};
    logic         exps [8]  = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    int           err_count = 0;
    int           tests_run = 0;
    int           cycles    = 0;

    rtdc_drive_control rtdc_drive_control_inst (.clock(clock), .resetn(resetn),
        .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .internal_transmit_envelope(env),
        .external_signal_input(ext), .carrier_tick(tick), .analog_q(analog_q),
        .pins_q(pins_q), .modulation_q(modulation_q), .mode_invalid_q(mode_invalid_q));
    rtdc_drv_model rtdc_drv_model_inst (.clock(clock), .analog(analog_q), .pins(pins_q),
        .first_level(first_level), .second_level(second_level), .drop_mv(drop_mv));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_addr  = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge clock);
        reg_write = 1'b0;
    endtask : wr

    // Read data is registered at the read edge, so it is taken one half cycle later
    task automatic rd(input logic [7:0] a);
        @(negedge clock);
        reg_addr = a;
        reg_read = 1'b1;
        @(negedge clock);
        reg_read = 1'b0;
        rd_val   = reg_rdata;
    endtask : rd

    task automatic pulse_tick;
        @(negedge clock);
        tick = 1'b1;
        @(negedge clock);
        tick = 1'b0;
    endtask : pulse_tick

    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // Cut a hang short well beyond the roughly 180 cycles the run needs
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            test_done();
        end
    end

    initial begin
        {resetn, reg_write, reg_read, env, ext, tick} = 6'h00;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        repeat (16) @(negedge clock);
        resetn = 1'b1;
        // Reset values, unmapped address, reserved bits
        for (int i = 0; i < 3; i++) begin
            rd(8'h28 + i[7:0]);
            chk(rd_val, 16'h0000);
        end
        wr(8'h2B, 8'hFF);
        rd(8'h2B);
        chk(rd_val, 16'h0000);
        wr(RTDC_ADDR_DRIVER_MODE, 8'hFF);
        rd(RTDC_ADDR_DRIVER_MODE);
        chk(rd_val, 16'h00CF);
        // Pin inversion and enable with no modulation
        wr(RTDC_ADDR_DRIVER_MODE, 8'hC8);
        cyc(2);
        chk({first_level, second_level}, 16'h0003);
        wr(RTDC_ADDR_DRIVER_MODE, 8'h48);
        cyc(2);
        chk({first_level, second_level}, 16'h0002);
        wr(RTDC_ADDR_DRIVER_MODE, 8'h40);
        cyc(2);
        chk({pins_q.first_enable, pins_q.second_enable}, 16'h0000);
        // Every clock mode code, the two unsupported ones flagged
        for (int m = 0; m < 8; m++) begin
            wr(RTDC_ADDR_DRIVER_MODE, 8'h08 | m[7:0]);
            cyc(2);
            chk(analog_q.clock_mode, m[2:0]);
            chk(mode_invalid_q, (m == 3 || m == 6));
        end
        // Amplitude presets and residual level
        for (int a = 0; a < 4; a++) begin
            wr(RTDC_ADDR_CARRIER_AMP, {a[1:0], 6'h35});
            rd(RTDC_ADDR_CARRIER_AMP);
            chk(rd_val, {a[1:0], 6'h15});
            cyc(1);
            chk(analog_q.amplitude_reduction, a[1:0]);
            chk(drop_mv, drops[a]);
            chk(analog_q.residual_level, 16'h0015);
        end
        wr(RTDC_ADDR_MOD_SOURCE, 8'h08);
        cyc(2);
        chk({analog_q.carrier_max, analog_q.amplitude_reduction}, 16'h0004);
        chk(drop_mv, 16'h0000);
        // Every source code, plain and inverted, envelope high, external low
        env = 1'b1;
        for (int s = 0; s < 8; s++) begin
            wr(RTDC_ADDR_MOD_SOURCE, sels[s]);
            cyc(4);
            chk(modulation_q, exps[s]);
        end
        // Envelope latency and pin drive follow
        wr(RTDC_ADDR_MOD_SOURCE, 8'h01);
        env = 1'b0;
        cyc(4);
        env = 1'b1;
        cyc(1);
        chk({modulation_q, pins_q.first_drive, pins_q.second_drive}, 16'h0007);
        // External input through its synchroniser
        wr(RTDC_ADDR_MOD_SOURCE, 8'h02);
        cyc(4);
        ext = 1'b1;
        cyc(2);
        chk(modulation_q, 16'h0000);
        cyc(1);
        chk(modulation_q, 16'h0001);
        // Overshoot holds modulation for three carrier clocks after the fall
        wr(RTDC_ADDR_MOD_SOURCE, 8'h31);
        cyc(3);
        env = 1'b0;
        cyc(1);
        chk(modulation_q, 16'h0001);
        cyc(3);
        chk(modulation_q, 16'h0001);
        pulse_tick();
        pulse_tick();
        chk(modulation_q, 16'h0001);
        pulse_tick();
        cyc(3);
        chk(modulation_q, 16'h0000);
        test_done();
    end
endmodule : tb
